// ===== verilog/pwc_regs.vh
// Register offsets, field positions, reset values and prescaler constants for the periodic wakeup counter.
// Assumes a simple one-cycle register port and one system clock with clock-enable style source ticks.
//
// Functional notes
// - Eight-bit up-counter compared with eight-bit modulo gives one periodic interrupt.
// - Counter keeps running in wait state when enabled beforehand.
// - Counter keeps running in stop2 and stop3, can wake processor.
// - Low power source usable in stop2 and stop3; others only in stop3.
// - With no clock source running, no wakeup from stop is possible.
// - Counting freezes while background debug mode is active.
// - After debug, counting continues from frozen value unless reconfigured.
// - Flag bit 7 sets on match; write one clears; reset clears.
// - Source select bits 6:5: 00 low power, 01 external, 1x internal.
// - Changed source select clears prescaler and counter.
// - Enable bit 4 gates flag onto interrupt request; reset clears.
// - Prescale select bits 3:0 reset to zero; change clears prescaler and counter.
// - Prescale zero is off; 1..15 pick binary or decimal divisors by row.
// - On match count returns to zero and flag sets; modulo zero flags each tick.
// - Modulo write clears prescaler and counter; reset sets modulo zero.
// - Count register is read-only and resets to zero.
`ifndef PWC_REGS_VH
`define PWC_REGS_VH

// ============================================================
// Register map (word index on the plain port)
`define PWC_ADDR_W 2
`define PWC_OFF_STATUS_CONTROL 2'h0
`define PWC_OFF_COUNT 2'h1
`define PWC_OFF_MODULO 2'h2
`define PWC_OFF_IRQ_MASK 2'h3

// ============================================================
// Status/control fields
`define PWC_FLAG_BIT 7
`define PWC_SRC_HI 6
`define PWC_SRC_LO 5
`define PWC_IE_BIT 4
`define PWC_PS_HI 3
`define PWC_PS_LO 0

// ============================================================
// Reset values
`define PWC_RST_SRC 2'h0
`define PWC_RST_PS 4'h0
`define PWC_RST_MOD 8'h00
`define PWC_RST_CNT 8'h00
`define PWC_RST_MASK 1'h1

// ============================================================
// Prescaler
`define PWC_PRE_W 18
`define PWC_SRC_LPO 2'h0
`define PWC_SRC_EXT 2'h1

`endif

// ===== verilog/pwc_prescaler.v
// Prescaler: counts source ticks and emits one pulse each time the selected divisor is reached.
// Assumes src_tick is a one-cycle pulse on mclk, one per rising edge of the chosen source.
`timescale 1ns/1ps
`default_nettype none
`include "pwc_regs.vh"

module pwc_prescaler (
	// Clock and reset
	input wire mclk,
	input wire resetn,
	// Control
	input wire clear,
	input wire freeze,
	input wire row_sel,
	input wire [3:0] prescale_select,
	input wire src_tick,
	// Output
	output reg out_tick
);

	reg [`PWC_PRE_W-1:0] div_count;
	reg [`PWC_PRE_W-1:0] divisor;

	// ============================================================
	// Divisor table
	always @* begin
		divisor = 18'h00001;
		case ({row_sel, prescale_select})
		5'h01: divisor = 18'h00008;
		5'h02: divisor = 18'h00020;
		5'h03: divisor = 18'h00040;
		5'h04: divisor = 18'h00080;
		5'h05: divisor = 18'h00100;
		5'h06: divisor = 18'h00200;
		5'h07: divisor = 18'h00400;
		5'h08: divisor = 18'h00001;
		5'h09: divisor = 18'h00002;
		5'h0A: divisor = 18'h00004;
		5'h0B: divisor = 18'h0000A;
		5'h0C: divisor = 18'h00010;
		5'h0D: divisor = 18'h00064;
		5'h0E: divisor = 18'h001F4;
		5'h0F: divisor = 18'h003E8;
		5'h11: divisor = 18'h00400;
		5'h12: divisor = 18'h00800;
		5'h13: divisor = 18'h01000;
		5'h14: divisor = 18'h02000;
		5'h15: divisor = 18'h04000;
		5'h16: divisor = 18'h08000;
		5'h17: divisor = 18'h10000;
		5'h18: divisor = 18'h003E8;
		5'h19: divisor = 18'h007D0;
		5'h1A: divisor = 18'h01388;
		5'h1B: divisor = 18'h02710;
		5'h1C: divisor = 18'h04E20;
		5'h1D: divisor = 18'h0C350;
		5'h1E: divisor = 18'h186A0;
		5'h1F: divisor = 18'h30D40;
		default: divisor = 18'h00001;
		endcase
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div_count <= 18'h00000;
			out_tick <= 1'b0;
		end else if (clear || prescale_select == `PWC_RST_PS) begin
			// Off or reconfigured: hold at zero
			div_count <= 18'h00000;
			out_tick <= 1'b0;
		end else if (freeze) begin
			out_tick <= 1'b0;
		end else if (src_tick) begin
			if (div_count == divisor - 18'h00001) begin
				div_count <= 18'h00000;
				out_tick <= 1'b1;
			end else begin
				div_count <= div_count + 18'h00001;
				out_tick <= 1'b0;
			end
		end else begin
			out_tick <= 1'b0;
		end
	end

endmodule // pwc_prescaler
`default_nettype wire

// ===== verilog/pwc_counter.v
// Periodic wakeup counter top: registers, source selection, counter, compare and interrupt.
// Assumes sources arrive as raw clocks from other domains; they are synchronised and edge-detected
// here, so each source must be well below half of mclk. Wait and stop need no special logic.
`timescale 1ns/1ps
`default_nettype none
`include "pwc_regs.vh"

module pwc_counter (
	// Clock and reset
	input wire mclk,
	input wire resetn,
	// Register port
	input wire [`PWC_ADDR_W-1:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	// Clock sources
	input wire low_power_osc,
	input wire external_ref_clock,
	input wire internal_ref_clock,
	input wire [2:0] source_running,
	// Mode
	input wire debug_active,
	// Interrupt
	output reg irq
);

	reg match_flag;
	reg match_irq_enable;
	reg [1:0] source_select;
	reg [3:0] prescale_select;
	reg [7:0] modulo_reg;
	reg [7:0] count_reg;
	reg irq_mask;
	reg [2:0] sync1;
	reg [2:0] sync2;
	reg [2:0] sync3;
	reg debug_s1;
	reg debug_s2;
	reg src_tick;
	reg next_src_tick;
	wire [2:0] src_rise;
	wire [2:0] src_raw;
	wire pre_tick;
	wire wr_sc;
	wire wr_mod;
	wire clear_all;
	wire match;

	assign src_raw = {internal_ref_clock, external_ref_clock, low_power_osc};
	assign wr_sc = wr && addr == `PWC_OFF_STATUS_CONTROL;
	assign wr_mod = wr && addr == `PWC_OFF_MODULO;

	// ============================================================
	// Source synchronisers and edge detect
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			always @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
				end else begin
					sync1[gi] <= src_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
				end
			end
			// A source that is not running yields no edges
			assign src_rise[gi] = sync2[gi] && !sync3[gi] && source_running[gi];
		end
	endgenerate

	// Source choice: 1x picks internal
	always @* begin
		case (source_select)
		`PWC_SRC_LPO: next_src_tick = src_rise[0];
		`PWC_SRC_EXT: next_src_tick = src_rise[1];
		default: next_src_tick = src_rise[2];
		endcase
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			src_tick <= 1'b0;
			debug_s1 <= 1'b0;
			debug_s2 <= 1'b0;
		end else begin
			src_tick <= next_src_tick;
			debug_s1 <= debug_active;
			debug_s2 <= debug_s1;
		end
	end

	// ============================================================
	// Reconfiguration clears prescaler and counter
	assign clear_all = wr_mod ||
		(wr_sc && (wdata[`PWC_SRC_HI:`PWC_SRC_LO] != source_select ||
		wdata[`PWC_PS_HI:`PWC_PS_LO] != prescale_select));

	pwc_prescaler u_pre (
		.mclk(mclk),
		.resetn(resetn),
		.clear(clear_all),
		.freeze(debug_s2),
		.row_sel(source_select[0]),
		.prescale_select(prescale_select),
		.src_tick(src_tick),
		.out_tick(pre_tick)
	);

	// ============================================================
	// Counter and compare
	assign match = count_reg == modulo_reg;

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= `PWC_RST_CNT;
		end else if (clear_all) begin
			count_reg <= 8'h00;
		end else if (pre_tick && !debug_s2) begin
			// Frozen in debug; keeps value for resume
			if (match) begin
				count_reg <= 8'h00;
			end else begin
				count_reg <= count_reg + 8'h01;
			end
		end
	end

	// ============================================================
	// Registers
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			match_flag <= 1'b0;
			match_irq_enable <= 1'b0;
			source_select <= `PWC_RST_SRC;
			prescale_select <= `PWC_RST_PS;
			modulo_reg <= `PWC_RST_MOD;
			irq_mask <= `PWC_RST_MASK;
		end else begin
			if (pre_tick && !debug_s2 && !clear_all && match) begin
				// Set wins over a simultaneous clear whose write keeps source and prescale unchanged
				match_flag <= 1'b1;
			end else if (wr_sc && wdata[`PWC_FLAG_BIT]) begin
				match_flag <= 1'b0;
			end
			if (wr_sc) begin
				match_irq_enable <= wdata[`PWC_IE_BIT];
				source_select <= wdata[`PWC_SRC_HI:`PWC_SRC_LO];
				prescale_select <= wdata[`PWC_PS_HI:`PWC_PS_LO];
			end
			if (wr_mod) begin
				modulo_reg <= wdata;
			end
			if (wr && addr == `PWC_OFF_IRQ_MASK) begin
				irq_mask <= wdata[0];
			end
		end
	end

	// ============================================================
	// Read port and interrupt; count writes are ignored
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
			irq <= 1'b0;
		end else begin
			// Flag gated by enable and mask
			irq <= match_flag && match_irq_enable && irq_mask;
			if (rd) begin
				case (addr)
				`PWC_OFF_STATUS_CONTROL: rdata <= {match_flag, source_select, match_irq_enable, prescale_select};
				`PWC_OFF_COUNT: rdata <= count_reg;
				`PWC_OFF_MODULO: rdata <= modulo_reg;
				`PWC_OFF_IRQ_MASK: rdata <= {7'h00, irq_mask};
				default: rdata <= 8'h00;
				endcase
			end else begin
				rdata <= 8'h00;
			end
		end
	end

endmodule // pwc_counter
`default_nettype wire

// ===== verif/pwc_counter_checker.sv
// Checker for the periodic wakeup counter top: read port, interrupt gating, freezing.
// Assumes it is bound to pwc_counter and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Checker
module pwc_counter_checker (
	// Clock and reset
	input wire mclk,
	input wire resetn,
	// Register port
	input wire [1:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	// Sources, mode and interrupt
	input wire [2:0] source_running,
	input wire debug_active,
	input wire irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("rdata not zero without a read");
	a_rdata_after_reset: assert property ($rose(resetn) |-> rdata == 8'h00)
		else $error("rdata not zero after reset");
	a_irq_after_reset: assert property ($rose(resetn) |-> !irq [*2])
		else $error("irq high after reset");
	a_ie_off_quiet: assert property (wr && addr == 2'h0 && !wdata[4] ##1 !wr |=> !irq)
		else $error("irq high with enable clear");
	a_mask_off_quiet: assert property (wr && addr == 2'h3 && !wdata[0] ##1 !wr |=> !irq)
		else $error("irq high with mask clear");
	a_irq_held: assert property (irq && !wr && !$past(wr) ##1 !wr |=> irq)
		else $error("irq dropped without a write");
	a_debug_no_wake: assert property ((debug_active && !wr) [*8] |=> !$rose(irq))
		else $error("irq rose while frozen");
	a_stop_no_wake: assert property ((source_running == 3'h0 && !wr) [*8] |=> !$rose(irq))
		else $error("irq rose with no source");
endmodule // pwc_counter_checker

bind pwc_counter pwc_counter_checker u_chk (.mclk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
	.source_running, .debug_active, .irq);
`default_nettype wire

// ===== verif/test_pwc_counter.sv
// Self-checking bench for pwc_counter against a small edge-counting model.
// Assumes the design and its checker are compiled first; all sources share one slow clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %0h got %0h", n, e, g); end end

// ============================================================
// Bench
module test_pwc_counter;
	reg mclk = 1'h0, resetn = 1'h0, wr = 1'h0, rd = 1'h0, debug_active = 1'h0, src = 1'h0, run = 1'h0;
	reg [1:0] addr = 2'h0;
	reg [7:0] wdata = 8'h00;
	reg [2:0] source_running = 3'h7;
	reg [7:0] tbl [0:3] = '{8'h08, 8'h48, 8'h49, 8'h00};
	wire [7:0] rdata;
	wire irq;
	integer checks = 0, mismatches = 0, seed = 25, cyc = 0, edges = 0, e0 = 0, m, n, c, i;
	integer dv [0:3] = '{1, 1, 2, 0};

	pwc_counter DUT (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .low_power_osc(src), .external_ref_clock(src), .internal_ref_clock(src),
		.source_running(source_running), .debug_active(debug_active), .irq(irq));

	always #25 mclk = ~mclk;
	// Source parks low when stopped, so restarting never fakes a rising edge
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 0) src <= run ? ~src : 1'h0;
		if (cyc > 20000) begin mismatches++; complete_run; end
	end
	always @(posedge src) edges++;

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wreg(input [1:0] a, input [7:0] d);
		@(posedge mclk) begin addr <= a; wdata <= d; wr <= 1'h1; end
		@(posedge mclk) wr <= 1'h0;
	endtask
	task automatic rreg(input [1:0] a, input [7:0] e);
		@(posedge mclk) begin addr <= a; rd <= 1'h1; end
		@(posedge mclk) rd <= 1'h0;
		@(negedge mclk);
		`CHK("rdata", e, rdata)
	endtask
	// Pipeline latency is fixed, so irq-to-irq source edges give the period
	task automatic sync_irq(input [7:0] v);
		wreg(2'h0, v);
		repeat (2) @(negedge mclk);
		for (c = 0; c < 4000 && irq !== 1'h1; c++) @(negedge mclk);
		n = edges - e0;
		e0 = edges;
	endtask
	task automatic burst(input integer k);
		run <= 1'h1;
		repeat (k) @(posedge mclk);
		run <= 1'h0;
		repeat (20) @(posedge mclk);
	endtask

	initial begin
		m = 2 + ($random(seed) & 3);
		repeat (5) @(posedge mclk);
		resetn <= 1'h1;
		rreg(2'h0, 8'h00);
		rreg(2'h1, 8'h00);
		rreg(2'h2, 8'h00);
		rreg(2'h3, 8'h01);
		run <= 1'h1;
		wreg(2'h2, m[7:0]);
		sync_irq(8'h98);
		sync_irq(8'h98);
		`CHK("period", m + 1, n)
		run <= 1'h0;
		repeat (20) @(posedge mclk);
		c = edges - e0;
		rreg(2'h0, 8'h98);
		rreg(2'h1, c[7:0]);
		wreg(2'h1, 8'h55);
		rreg(2'h1, c[7:0]);
		wreg(2'h0, 8'h18);
		rreg(2'h0, 8'h98);
		wreg(2'h0, 8'h98);
		rreg(2'h0, 8'h18);
		`CHK("irq", 1'h0, irq)
		wreg(2'h2, 8'h00);
		wreg(2'h0, 8'h08);
		run <= 1'h1;
		repeat (40) @(negedge mclk);
		rreg(2'h0, 8'h88);
		`CHK("irq", 1'h0, irq)
		wreg(2'h0, 8'h18);
		repeat (2) @(negedge mclk);
		`CHK("irq", 1'h1, irq)
		wreg(2'h3, 8'h00);
		repeat (2) @(negedge mclk);
		`CHK("irq", 1'h0, irq)
		wreg(2'h3, 8'h01);
		sync_irq(8'h98);
		sync_irq(8'h98);
		`CHK("period", 1, n)
		sync_irq(8'h99);
		sync_irq(8'h99);
		`CHK("period", 2, n)
		run <= 1'h0;
		wreg(2'h2, 8'hFF);
		for (i = 0; i < 4; i++) begin
			wreg(2'h0, tbl[i]);
			e0 = edges;
			burst(60);
			c = dv[i] ? (edges - e0) / dv[i] : 0;
			rreg(2'h1, c[7:0]);
		end
		for (i = 0; i < 2; i++) begin
			wreg(2'h0, i ? 8'h48 : 8'h08);
			e0 = edges;
			burst(30);
			c = edges - e0;
			// Sources are stopped or restarted only while parked low
			@(posedge mclk) begin debug_active <= (i == 0); source_running <= i ? 3'h0 : 3'h7; end
			repeat (10) @(posedge mclk);
			burst(40);
			rreg(2'h1, c[7:0]);
			@(posedge mclk) begin debug_active <= 1'h0; source_running <= 3'h7; end
			repeat (10) @(posedge mclk);
			e0 = edges;
			burst(30);
			c = c + edges - e0;
			rreg(2'h1, c[7:0]);
		end
		complete_run;
	end
endmodule // test_pwc_counter
`default_nettype wire
